// *** src/mslc_lock_gate.sv ***
// Lock fault gating with sticky write-one-to-clear flags
`timescale 1ns/1ps
`default_nettype none
module mslc_lock_gate (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       srst,
    // Enables, raw conditions and software clear
    input  wire logic [5:0] enable,
    input  wire logic [5:0] cond,
    input  wire logic [5:0] clear,
    // Fault state
    output logic      [5:0] flags,
    output logic            fault
);
    logic [5:0] flags_r;
    logic [5:0] flags_nxt;
    logic       fault_r;
    logic [5:0] set_w;

    // A condition is only a fault while its enable bit is high
    assign set_w = cond & enable; // R7 R8 R9 R10 R11 R12
    // Set wins over clear so an event in the clear cycle survives
    assign flags_nxt = (flags_r & ~clear) | set_w;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            flags_r <= mslc_pkg::LOCK_STAT_RST;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            fault_r <= 1'b0;
        end else begin
            fault_r <= |flags_nxt;
        end
    end

    assign flags = flags_r;
    assign fault = fault_r;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    set_wins_a: assert property ((set_w & clear) != 6'h00 |=> // R7
        (flags_r & $past(set_w & clear)) == $past(set_w & clear))
        else $error("Lock flag lost when set met clear");
    no_stray_a: assert property (1'b1 |=> // R12
        (flags_r & ~$past(flags_r) & ~$past(set_w)) == 6'h00)
        else $error("Lock flag set without enabled condition");
    fault_any_a: assert property ((cond & enable) != 6'h00 |=> // R12
        fault_r && (flags_r & $past(cond & enable)) == $past(cond & enable))
        else $error("Enabled lock condition not flagged");
endmodule // mslc_lock_gate
`default_nettype wire

// *** src/mslc_pkg.sv ***
// Register map, field layout and decode tables of the configuration bank
package mslc_pkg;
    // Overview of operation
    // R1 - Second-order accel: fast/slow table, 111 zero
    // R2 - First-order accel: halving fast and slow tables
    // R3 - Handover range 0: low bits times 0.8 Hz
    // R4 - Handover range 1: low bits plus one, 12.8 Hz
    // R5 - Align time code selects 5.3 s to 0.04 s
    // R6 - Hot cap: 00 soft only, else 1/1.6/2 A
    // R7 - Bit 13 enables closed-loop no zero-cross lock
    // R8 - Bit 12 enables open-loop no zero-cross lock
    // R9 - Bit 11 enables missing motor lock fault
    // R10 - Bit 10 enables motor constant window fault
    // R11 - Bit 9 enables abnormal speed lock fault
    // R12 - Bit 8 enables hard current limit fault
    // R13 - Soft limit: 0000 off, else n times 0.2 A
    // R14 - Range bit 0: low two bits pick limit
    // R15 - Range bit 1: 0.4 A steps up to 3.2 A
    // R16 - Protection register resets to all zeros
    // R17 - Accel range bit: 0 fast, 1 slow tables
    // R18 - Fields read back last write or reset value

    localparam int          ADDR_W         = 12;
    localparam int          DATA_W         = 32;
    localparam int          LOCK_N         = 6;
    // Word indices; the byte address is four times the index
    localparam logic [7:0]  STARTUP_IDX    = 8'h93;
    localparam logic [7:0]  PROT_IDX       = 8'h94;
    localparam logic [7:0]  LOCK_STAT_IDX  = 8'h9f;
    localparam logic [11:0] STARTUP_ADDR   = {2'b00, STARTUP_IDX, 2'b00};
    localparam logic [11:0] PROT_ADDR      = {2'b00, PROT_IDX, 2'b00};
    localparam logic [11:0] LOCK_STAT_ADDR = {2'b00, LOCK_STAT_IDX, 2'b00};

    localparam logic [15:0] STARTUP_RST    = 16'h0000;
    localparam logic [15:0] PROT_RST       = 16'h0000;
    localparam logic [15:0] STARTUP_WMASK  = 16'h7fff;
    localparam logic [5:0]  LOCK_STAT_RST  = 6'h00;

    // Field positions
    localparam int ACC_SEL_BIT    = 14;
    localparam int ACC2_LSB       = 11;
    localparam int ACC1_LSB       = 8;
    localparam int THR_LSB        = 3;
    localparam int ALIGN_LSB      = 0;
    localparam int HOT_LSB        = 14;
    localparam int LOCK_EN_LSB    = 8;
    localparam int SOFT_LSB       = 4;
    localparam int HARD_LSB       = 1;
    localparam int HARD_RANGE_BIT = 0;
    localparam int STAT_OT_BIT    = 8;

    // Coefficients in thousandths of Hz/s^2 and Hz/s
    localparam logic [15:0] ACC2_FAST [8] = '{16'hdea8, 16'h7148,
        16'h36b0, 16'h1af4, 16'h0ce4, 16'h0640, 16'h0294, 16'h0000};
    localparam logic [15:0] ACC2_SLOW [8] = '{16'h00dc, 16'h006e,
        16'h0037, 16'h001b, 16'h000d, 16'h0006, 16'h0003, 16'h0000};
    localparam logic [16:0] ACC1_FAST [8] = '{17'h1_28e0, 17'h0_9470,
        17'h0_4a38, 17'h0_23f0, 17'h0_1194, 17'h0_0834, 17'h0_0384,
        17'h0_012c};
    localparam logic [16:0] ACC1_SLOW [8] = '{17'h0_12c0, 17'h0_0960,
        17'h0_04b0, 17'h0_0244, 17'h0_0118, 17'h0_0082, 17'h0_003c,
        17'h0_0013};
    // Align time in ms
    localparam logic [12:0] ALIGN_MS  [8] = '{13'h14b4, 13'h0a8c,
        13'h0514, 13'h029e, 13'h014a, 13'h00a0, 13'h0050, 13'h0028};
    // Threshold steps in tenths of Hz, currents in mA
    localparam logic [11:0] THR_STEP0 = 12'h008;
    localparam logic [11:0] THR_STEP1 = 12'h080;
    localparam logic [11:0] SOFT_STEP = 12'h0c8;
    localparam logic [11:0] HARD_STEP = 12'h190;
    localparam logic [11:0] HOT_CAP   [4] = '{12'h000, 12'h3e8,
        12'h640, 12'h7d0};
    localparam logic [11:0] HARD_R0   [4] = '{12'h9c4, 12'h76c,
        12'h5dc, 12'h384};
endpackage

// *** src/mslc_top.sv ***
// Start-up and protection configuration bank behind an APB slave
`timescale 1ns/1ps
`default_nettype none
module mslc_top (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        srst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Motor engine observations
    input  wire logic        ot_warning,
    input  wire logic        closed_loop_stuck,
    input  wire logic        open_loop_stuck,
    input  wire logic        motor_missing,
    input  wire logic        motor_constant_bad,
    input  wire logic        speed_abnormal,
    input  wire logic [11:0] phase_current_ma,
    // Start-up settings
    output logic      [15:0] accel2_coeff,
    output logic      [16:0] accel1_coeff,
    output logic      [11:0] handover_thr,
    output logic             handover_thr_valid,
    output logic      [12:0] align_ms,
    // Protection settings
    output logic      [11:0] current_limit_ma,
    output logic             current_limit_en,
    output logic      [11:0] hard_limit_ma,
    output logic      [5:0]  lock_enable,
    output logic      [5:0]  lock_fault_flags,
    output logic             lock_fault
);
    // Software registers
    logic [15:0] startup_r;
    logic [15:0] prot_r;
    // Bus answer
    logic [31:0] prdata_r;
    logic        err_r;
    logic [31:0] rd_word;
    // Decoded settings
    logic [15:0] accel2_r;
    logic [16:0] accel1_r;
    logic [11:0] thr_r;
    logic        thr_valid_r;
    logic [12:0] align_r;
    logic [11:0] cur_lim_r;
    logic        cur_en_r;
    logic [11:0] hard_lim_r;
    // Bus decode
    logic        setup_phase;
    logic        wr_en;
    logic        hit_startup;
    logic        hit_prot;
    logic        hit_stat;
    logic        hit_any;
    // Fields
    logic        acc_sel;
    logic [2:0]  acc2_code;
    logic [2:0]  acc1_code;
    logic [4:0]  thr_code;
    logic [2:0]  align_code;
    logic [1:0]  hot_code;
    logic [3:0]  soft_code;
    logic [2:0]  hard_code;
    logic        hard_range;
    // Lock detection
    logic [5:0]  lock_cond;
    logic [5:0]  lock_clear;
    logic [5:0]  lock_flags;
    logic        lock_fault_w;

    // Only the low two lanes hold register bits
    function automatic logic [15:0] merge_bytes(
        input logic [15:0] old,
        input logic [31:0] wd,
        input logic [3:0]  strb
    );
        logic [15:0] res;
        res = old;
        for (int b = 0; b < 2; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = wd[8*b +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic [11:0] thr_f(input logic [4:0] c);
        logic [11:0] n;
        n = {8'h00, c[3:0]};
        if (c[4]) begin
            return (n + 12'h001) * mslc_pkg::THR_STEP1; // R4
        end
        return n * mslc_pkg::THR_STEP0; // R3
    endfunction

    function automatic logic [11:0] hard_f(
        input logic       rng,
        input logic [2:0] c
    );
        logic [11:0] n;
        n = {9'h000, c};
        if (rng) begin
            return (n + 12'h001) * mslc_pkg::HARD_STEP; // R15
        end
        // Top code bit is ignored in this range
        return mslc_pkg::HARD_R0[c[1:0]]; // R14
    endfunction

    function automatic logic [11:0] soft_f(input logic [3:0] c);
        return {8'h00, c} * mslc_pkg::SOFT_STEP; // R13
    endfunction

    assign acc_sel    = startup_r[mslc_pkg::ACC_SEL_BIT];
    assign acc2_code  = startup_r[mslc_pkg::ACC2_LSB +: 3];
    assign acc1_code  = startup_r[mslc_pkg::ACC1_LSB +: 3];
    assign thr_code   = startup_r[mslc_pkg::THR_LSB +: 5];
    assign align_code = startup_r[mslc_pkg::ALIGN_LSB +: 3];
    assign hot_code   = prot_r[mslc_pkg::HOT_LSB +: 2];
    assign soft_code  = prot_r[mslc_pkg::SOFT_LSB +: 4];
    assign hard_code  = prot_r[mslc_pkg::HARD_LSB +: 3];
    assign hard_range = prot_r[mslc_pkg::HARD_RANGE_BIT];

    // Zero-wait slave: every access completes in its first access cycle
    assign setup_phase = psel && !penable;
    assign wr_en       = psel && penable && pwrite;
    assign hit_startup = paddr == mslc_pkg::STARTUP_ADDR;
    assign hit_prot    = paddr == mslc_pkg::PROT_ADDR;
    assign hit_stat    = paddr == mslc_pkg::LOCK_STAT_ADDR;
    assign hit_any     = hit_startup || hit_prot || hit_stat;

    always_comb begin
        rd_word = '0;
        if (hit_startup) begin
            rd_word[15:0] = startup_r; // R18
        end else if (hit_prot) begin
            rd_word[15:0] = prot_r; // R18
        end else if (hit_stat) begin
            rd_word[5:0] = lock_flags;
            rd_word[mslc_pkg::STAT_OT_BIT] = ot_warning;
        end
    end

    // Read data is captured in setup so prdata comes from a flop
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            prdata_r <= '0;
            err_r    <= 1'b0;
        end else if (setup_phase) begin
            prdata_r <= pwrite ? '0 : rd_word;
            err_r    <= !hit_any;
        end
    end

    assign prdata  = prdata_r;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && err_r;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            startup_r <= mslc_pkg::STARTUP_RST;
        end else if (wr_en && hit_startup) begin
            // Reserved top bit stays zero
            startup_r <= merge_bytes(startup_r, pwdata, pstrb)
                & mslc_pkg::STARTUP_WMASK; // R18
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            prot_r <= mslc_pkg::PROT_RST; // R16
        end else if (wr_en && hit_prot) begin
            prot_r <= merge_bytes(prot_r, pwdata, pstrb); // R18
        end
    end

    // Start-up decode
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            accel2_r <= '0;
            accel1_r <= '0;
        end else begin
            accel2_r <= acc_sel ? mslc_pkg::ACC2_SLOW[acc2_code]
                                : mslc_pkg::ACC2_FAST[acc2_code]; // R1 R17
            accel1_r <= acc_sel ? mslc_pkg::ACC1_SLOW[acc1_code]
                                : mslc_pkg::ACC1_FAST[acc1_code]; // R2 R17
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            thr_r       <= '0;
            thr_valid_r <= 1'b0;
            align_r     <= '0;
        end else begin
            thr_r       <= thr_f(thr_code);
            // An all-zero code names no handover speed
            thr_valid_r <= thr_code != 5'b00000; // R3
            align_r     <= mslc_pkg::ALIGN_MS[align_code]; // R5
        end
    end

    // Protection decode
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cur_lim_r <= '0;
            cur_en_r  <= 1'b0;
        end else if (ot_warning && hot_code != 2'b00) begin
            cur_lim_r <= mslc_pkg::HOT_CAP[hot_code]; // R6
            cur_en_r  <= 1'b1;
        end else begin
            cur_lim_r <= soft_f(soft_code); // R6
            cur_en_r  <= soft_code != 4'h0; // R13
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            hard_lim_r <= mslc_pkg::HARD_R0[0];
        end else begin
            hard_lim_r <= hard_f(hard_range, hard_code);
        end
    end

    // Current reaching the lock limit is judged here
    assign lock_cond = {closed_loop_stuck, open_loop_stuck, motor_missing,
        motor_constant_bad, speed_abnormal,
        phase_current_ma >= hard_lim_r}; // R12
    assign lock_clear = (wr_en && hit_stat && pstrb[0])
        ? pwdata[5:0] : 6'h00;

    mslc_lock_gate u_lock (
        .ref_clk (ref_clk),
        .srst    (srst),
        .enable  (prot_r[mslc_pkg::LOCK_EN_LSB +: mslc_pkg::LOCK_N]),
        .cond    (lock_cond),
        .clear   (lock_clear),
        .flags   (lock_flags),
        .fault   (lock_fault_w)
    );

    assign accel2_coeff       = accel2_r;
    assign accel1_coeff       = accel1_r;
    assign handover_thr       = thr_r;
    assign handover_thr_valid = thr_valid_r;
    assign align_ms           = align_r;
    assign current_limit_ma   = cur_lim_r;
    assign current_limit_en   = cur_en_r;
    assign hard_limit_ma      = hard_lim_r;
    assign lock_enable        = prot_r[mslc_pkg::LOCK_EN_LSB +: 6];
    assign lock_fault_flags   = lock_flags;
    assign lock_fault         = lock_fault_w;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    sequence prot_write_s;
        psel && penable && pwrite && paddr == mslc_pkg::PROT_ADDR
            && pstrb[1:0] == 2'b11;
    endsequence

    sequence prot_read_s;
        psel && !penable && !pwrite && paddr == mslc_pkg::PROT_ADDR
            ##1 psel && penable;
    endsequence

    sequence startup_read_s;
        psel && !penable && !pwrite && paddr == mslc_pkg::STARTUP_ADDR
            ##1 psel && penable;
    endsequence

    prot_write_a: assert property (prot_write_s |=> // R18
        prot_r == $past(pwdata[15:0]))
        else $error("Protection write not stored");
    prot_readback_a: assert property (prot_read_s |-> // R18
        prdata == {16'h0000, prot_r} && !pslverr)
        else $error("Protection readback wrong");
    startup_readback_a: assert property (startup_read_s |-> // R18
        prdata[15:0] == startup_r && prdata[15] == 1'b0)
        else $error("Start-up readback wrong");
    reset_zero_a: assert property (disable iff (1'b0) // R16
        srst |=> prot_r == 16'h0000 && startup_r == 16'h0000)
        else $error("Registers not zero after reset");
    accel2_zero_a: assert property (acc2_code == 3'b111 |=> // R1
        accel2_coeff == 16'h0000)
        else $error("Second-order code 111 not zero");
    accel2_fast_a: assert property (!acc_sel && acc2_code == 3'b000 // R1
        |=> accel2_coeff == 16'hdea8)
        else $error("Fast second-order first entry wrong");
    accel_slow_a: assert property (acc_sel && acc1_code == 3'b111 // R17
        |=> accel1_coeff == 17'h0_0013 && accel2_coeff < 16'h00dd)
        else $error("Slow table not selected");
    accel1_fast_a: assert property (!acc_sel && acc1_code == 3'b000 // R2
        |=> accel1_coeff == 17'h1_28e0)
        else $error("Fast first-order first entry wrong");
    thr_low_a: assert property (!thr_code[4] |=> // R3
        handover_thr == {5'b00000, $past(thr_code[3:0]), 3'b000}
        && handover_thr_valid == ($past(thr_code) != 5'b00000))
        else $error("Handover range 0 wrong");
    thr_high_a: assert property (thr_code[4] |=> handover_thr == // R4
        ({8'h00, $past(thr_code[3:0])} + 12'h001) << 7)
        else $error("Handover range 1 wrong");
    align_long_a: assert property (align_code == 3'b000 |=> // R5
        align_ms == 13'h14b4)
        else $error("Longest align time wrong");
    hot_cap_a: assert property (ot_warning && hot_code == 2'b01 // R6
        |=> current_limit_ma == 12'h3e8 && current_limit_en)
        else $error("Hot current cap not applied");
    soft_off_a: assert property (soft_code == 4'h0 // R13
        && !(ot_warning && hot_code != 2'b00) |=> !current_limit_en)
        else $error("Soft limit not disabled at code 0");
    hard_low_a: assert property (!hard_range && hard_code[1:0] == 2'b11 // R14
        |=> hard_limit_ma == 12'h384)
        else $error("Hard limit range 0 wrong");
    hard_high_a: assert property (hard_range && hard_code == 3'b111 // R15
        |=> hard_limit_ma == 12'hc80)
        else $error("Hard limit range 1 wrong");
    lock_gate_a: assert property (lock_enable == 6'h00 // R9
        && lock_fault_flags == 6'h00 |=> !lock_fault)
        else $error("Lock fault raised with all enables off");
endmodule // mslc_top
`default_nettype wire

// *** test/tb_mslc_top.sv ***
// Self-checking bench for the start-up and protection register bank
`timescale 1ns/1ps
`default_nettype none
module tb_mslc_top;
    logic        ref_clk = 1'b0;
    logic        srst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0]  pstrb = 4'hf;
    logic        ot_warning = 1'b0;
    logic [5:1]  lc = 5'h00;
    logic [11:0] phase_ma = 12'h000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [15:0] accel2_coeff;
    logic [16:0] accel1_coeff;
    logic [11:0] handover_thr;
    logic        handover_thr_valid;
    logic [12:0] align_ms;
    logic [11:0] current_limit_ma;
    logic        current_limit_en;
    logic [11:0] hard_limit_ma;
    logic [5:0]  lock_enable;
    logic [5:0]  lock_fault_flags;
    logic        lock_fault;
    logic [31:0] rdat;
    logic        rerr;
    int          errors = 0;
    int          samples_checked = 0;

    always #4 ref_clk = ~ref_clk;

    mslc_top mslc_top_i (
        .ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ot_warning(ot_warning), .closed_loop_stuck(lc[5]),
        .open_loop_stuck(lc[4]), .motor_missing(lc[3]),
        .motor_constant_bad(lc[2]), .speed_abnormal(lc[1]),
        .phase_current_ma(phase_ma), .accel2_coeff(accel2_coeff),
        .accel1_coeff(accel1_coeff), .handover_thr(handover_thr),
        .handover_thr_valid(handover_thr_valid), .align_ms(align_ms),
        .current_limit_ma(current_limit_ma),
        .current_limit_en(current_limit_en), .hard_limit_ma(hard_limit_ma),
        .lock_enable(lock_enable), .lock_fault_flags(lock_fault_flags),
        .lock_fault(lock_fault)
    );

    task automatic final_report();
        $display("comparisons %0d, mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            errors++;
            $display("unexpected pready: expected 1, seen %b", pready);
            final_report();
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Decoded outputs trail a register write by one extra cycle
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        repeat (3) @(posedge ref_clk);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk("read data", exp, rdat);
        chk("read error", 32'h0000_0000, 32'(rerr));
    endtask

    task automatic t_reset();
        rd(mslc_pkg::STARTUP_ADDR, 32'h0000_0000);
        rd(mslc_pkg::PROT_ADDR, 32'h0000_0000);
        chk("accel2", 32'h0000_dea8, 32'(accel2_coeff));
        chk("accel1", 32'h0001_28e0, 32'(accel1_coeff));
        chk("align", 32'h0000_14b4, 32'(align_ms));
        chk("hard", 32'h0000_09c4, 32'(hard_limit_ma));
        chk("lock en", 32'h0000_0000, 32'(lock_enable));
        chk("soft en", 32'h0000_0000, 32'(current_limit_en));
        $display("reset values done");
    endtask

    task automatic t_startup();
        logic [15:0] v;
        logic [2:0]  c;
        logic [4:0]  t;
        for (int i = 0; i < 16; i++) begin
            c = i[2:0];
            // Bit 15 is written high on purpose; it must read back 0
            v = {1'b1, i[3], c, c, 5'b00000, c};
            wr(mslc_pkg::STARTUP_ADDR, {16'h0000, v});
            chk("accel2", 32'(i[3] ? mslc_pkg::ACC2_SLOW[c] :
                mslc_pkg::ACC2_FAST[c]), 32'(accel2_coeff));
            chk("accel1", 32'(i[3] ? mslc_pkg::ACC1_SLOW[c] :
                mslc_pkg::ACC1_FAST[c]), 32'(accel1_coeff));
            chk("align", 32'(mslc_pkg::ALIGN_MS[c]), 32'(align_ms));
            rd(mslc_pkg::STARTUP_ADDR, {17'h0_0000, v[14:0]});
        end
        for (int n = 0; n < 32; n++) begin
            t = n[4:0];
            wr(mslc_pkg::STARTUP_ADDR, {24'h00_0000, t, 3'b000});
            chk("thr", t[4] ? 32'(t[3:0] + 5'd1) * 32'h0000_0080 :
                32'(t[3:0]) * 32'h0000_0008, 32'(handover_thr));
            chk("thr valid", 32'(t != 5'h00),
                32'(handover_thr_valid));
        end
        $display("start-up decode done");
    endtask

    task automatic t_protect();
        logic [11:0] cap [4];
        logic [11:0] r0 [4];
        cap = '{12'h000, 12'h3e8, 12'h640, 12'h7d0};
        r0 = '{12'h9c4, 12'h76c, 12'h5dc, 12'h384};
        for (int n = 0; n < 16; n++) begin
            wr(mslc_pkg::PROT_ADDR, 32'(n) << 4);
            chk("soft", 32'(n) * 32'h0000_00c8,
                32'(current_limit_ma));
            chk("soft en", 32'(n != 0), 32'(current_limit_en));
        end
        ot_warning <= 1'b1;
        for (int h = 0; h < 4; h++) begin
            wr(mslc_pkg::PROT_ADDR, (32'(h) << 14) | 32'h0000_0030);
            chk("hot", 32'(h == 0 ? 12'h258 : cap[h]),
                32'(current_limit_ma));
            rd(mslc_pkg::PROT_ADDR, (32'(h) << 14) | 32'h0000_0030);
        end
        rd(mslc_pkg::LOCK_STAT_ADDR, 32'h0000_0100);
        ot_warning <= 1'b0;
        repeat (3) @(posedge ref_clk);
        chk("hot off", 32'h0000_0258, 32'(current_limit_ma));
        for (int i = 0; i < 16; i++) begin
            wr(mslc_pkg::PROT_ADDR, {28'h000_0000, i[2:0], i[3]});
            chk("hard", i[3] ? 32'(i[2:0] + 4'd1) * 32'h0000_0190 :
                32'(r0[i[1:0]]), 32'(hard_limit_ma));
        end
        $display("protection decode done");
    endtask

    // Raise one condition for one cycle, then look at the sticky flags
    task automatic pulse(input int j, input logic [11:0] ma);
        if (j == 0) phase_ma <= ma;
        else lc[j] <= 1'b1;
        @(posedge ref_clk);
        phase_ma <= 12'h000;
        lc <= 5'h00;
        @(posedge ref_clk);
    endtask

    task automatic t_lock();
        for (int j = 0; j < 6; j++) begin
            wr(mslc_pkg::PROT_ADDR, 32'h0000_0100 << j);
            chk("lock en", 32'h0000_0001 << j, 32'(lock_enable));
            pulse(j, 12'h9c4);
            chk("flags", 32'h0000_0001 << j,
                32'(lock_fault_flags));
            chk("fault", 32'h0000_0001, 32'(lock_fault));
            wr(mslc_pkg::LOCK_STAT_ADDR, 32'h0000_003f);
            chk("cleared", 32'h0000_0000, 32'(lock_fault_flags));
        end
        // Condition held across the clear: the set must win
        wr(mslc_pkg::PROT_ADDR, 32'h0000_0300);
        lc[1] <= 1'b1;
        wr(mslc_pkg::LOCK_STAT_ADDR, 32'h0000_003f);
        chk("set over clear", 32'h0000_0002,
            32'(lock_fault_flags));
        lc <= 5'h00;
        wr(mslc_pkg::LOCK_STAT_ADDR, 32'h0000_003f);
        // Current enable is on, so only the threshold keeps this quiet
        pulse(0, 12'h9c3);
        chk("below hard", 32'h0000_0000, 32'(lock_fault_flags));
        wr(mslc_pkg::PROT_ADDR, 32'h0000_0000);
        for (int j = 0; j < 6; j++) pulse(j, 12'hfff);
        chk("disabled", 32'h0000_0000,
            32'(lock_fault_flags));
        $display("lock detection done");
    endtask

    task automatic t_unmapped();
        apb(1'b0, 12'h300, 32'h0000_0000);
        chk("err", 32'h0000_0001, 32'(rerr));
        chk("err data", 32'h0000_0000, rdat);
        apb(1'b1, 12'h254, 32'h0000_ffff);
        chk("err", 32'h0000_0001, 32'(rerr));
        rd(mslc_pkg::PROT_ADDR, 32'h0000_0000);
        // Only lane 1 enabled: the low byte must keep its old value
        pstrb <= 4'h2;
        wr(mslc_pkg::PROT_ADDR, 32'h0000_abcd);
        pstrb <= 4'hf;
        rd(mslc_pkg::PROT_ADDR, 32'h0000_ab00);
        $display("unmapped access done");
    endtask

    initial begin
        repeat (4) @(posedge ref_clk);
        srst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        t_reset();
        t_startup();
        t_protect();
        t_lock();
        t_unmapped();
        final_report();
    end
endmodule // tb_mslc_top
`default_nettype wire
